//--- inc/rsc_pkg.sv
// Shared constants and types of the reset, standby and frame-sync control block
package rsc_pkg;

  // Register map, two-wire serial 16-bit addresses
  localparam logic [15:0] OFS_CAMERA_OPERATING_MODE = 16'hc88c;
  localparam logic [15:0] OFS_TEST_PATTERN_CHOICE   = 16'hc88f;
  localparam logic [15:0] OFS_SOFT_RESET_CTRL       = 16'hc8f0;
  localparam logic [15:0] OFS_CONTROL_STATUS        = 16'hc8f4;

  // Values after reset
  localparam logic [7:0]  RST_CAMERA_OPERATING_MODE = 8'h00;
  localparam logic [7:0]  RST_TEST_PATTERN_CHOICE   = 8'h00;
  localparam logic [15:0] RST_LFSR_SEED             = 16'hace1;

  // Operating mode and pattern encodings
  localparam logic [7:0] MODE_NORMAL  = 8'h00;
  localparam logic [7:0] MODE_TEST    = 8'h02;
  localparam logic [7:0] PAT_PRBS     = 8'h05;
  localparam logic [7:0] PAT_FADE     = 8'h08;
  localparam logic [7:0] PAT_RAMP     = 8'h09;
  localparam logic [7:0] PAT_BAR_N7   = 8'h14;
  localparam logic [7:0] PAT_BAR_N8   = 8'h15;
  localparam logic [7:0] PAT_BAR_P7   = 8'h1e;
  localparam logic [7:0] PAT_BAR_P8   = 8'h1f;

  // Positions of the synchronised pin inputs
  localparam int IN_FA  = 0;
  localparam int IN_SB  = 1;
  localparam int IN_SCL = 2;
  localparam int IN_SDA = 3;
  localparam int IN_GP  = 4;
  localparam int IN_W   = 8;

  // Cycle counts in reference clock cycles; RESYNC_FIELDS counts fields
  localparam logic [3:0]  STRAP_CYC      = 4'h4;
  localparam logic [11:0] SOFT_RST_CYC   = 12'h040;
  localparam logic [3:0]  RESYNC_FIELDS  = 4'h2;
  localparam int          HOST_RST_MIN   = 50;
  localparam int          HOST_CLK_GUARD = 10;
  localparam int          HOST_FIRST_SER = 100;

  typedef enum logic [2:0] {M_DEFAULT, M_RUN, M_STBY_WAIT, M_STANDBY, M_SOFT} rsc_main_t;
  typedef enum logic [1:0] {SY_IDLE, SY_STOP, SY_BLACK} rsc_sync_t;
  typedef enum logic [2:0] {SR_IDLE, SR_RX, SR_ACK, SR_TX, SR_RACK} rsc_ser_t;

endpackage : rsc_pkg

//--- logic/rsc_control.sv
// Reset, standby, frame-sync, test pattern and serial register control
// Notes on behaviour
// - Hard reset input low puts the whole block into its reset state.
// - In reset every output pin except sensor reset is released to high impedance.
// - A write with bit 0 set to the soft reset register starts a soft reset sequence.
// - Standby input high enters hard standby within two frames, unless it arrives with an interlaced sync rise or single-shot frame end.
// - Standby input low leaves hard standby.
// - Interlaced: frame sync rise stops the current frame output.
// - Interlaced: frame sync fall starts resync, black fields until done.
// - Interlaced: frame sync toggles ignored until resync has finished.
// - Progressive: frame sync pulse is forwarded to the capture trigger output.
// - Single-shot trigger mode outputs exactly one frame per trigger.
// - Continuous trigger mode starts continuous frame output on a trigger.
// - Aligned devices match frame-valid within 5 pixel clocks.
// - Pattern 0x05 pseudo-random, 0x08 fade-to-gray, 0x09 linear ramp.
// - Mode 0x02 enters, 0x00 leaves test; acts only on apply request.
// - Colour bar patterns are accepted only in interlaced operation.
// - Active test mode replaces sensor data with the generated pattern.
// - After reset GPIO 5..2 are sampled as straps, then left released.
// - Sensor reset output is held low in reset and default states.
`timescale 1ns/1ps
`default_nettype none
module rsc_control
  import rsc_pkg::*;
#(
  parameter int          H_TOTAL  = 64,
  parameter int          H_ACTIVE = 48,
  parameter int          V_TOTAL  = 16,
  parameter int          V_ACTIVE = 12,
  parameter int          HW       = 12,
  parameter int          VW       = 12,
  // Arbitrary value, not tied to any product
  parameter logic [6:0]  DEV_ADDR = 7'h3a
) (
  // Clock and hard reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Host control pins
  input  wire logic        standby_in,
  input  wire logic        frame_align_in,
  input  wire logic [3:0]  gpio_in,
  // Two-wire serial interface
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  output      logic        ser_data_out,
  output      logic        ser_data_oe_n,
  // Firmware-side configuration, same clock
  input  wire logic        interlaced_mode,
  input  wire logic        trigger_continuous,
  input  wire logic        apply_settings,
  // Sensor data in
  input  wire logic [15:0] sensor_data_in,
  // Video out
  output      logic        frame_valid_output,
  output      logic        line_valid_output,
  output      logic        pixel_clock_output,
  output      logic [15:0] pixel_data_out,
  output      logic        video_oe_n,
  // Sensor side
  output      logic        capture_trigger_out,
  output      logic        capture_trigger_oe_n,
  output      logic        sensor_reset_n_out,
  output      logic [3:0]  gpio_oe_n
);

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic [IN_W-1:0] filt;
    logic [IN_W-1:0] prev;
    rsc_main_t       main;
    rsc_sync_t       sy;
    rsc_ser_t        ser;
    logic [11:0]     wait_cnt;
    logic [15:0]     sb_cnt;
    logic [3:0]      strap;
    logic [HW-1:0]   hcnt;
    logic [VW-1:0]   vcnt;
    logic            run;
    logic            cont;
    logic [3:0]      fld;
    logic [7:0]      mode_pend;
    logic [7:0]      choice_pend;
    logic [7:0]      mode_act;
    logic [7:0]      choice_act;
    logic [15:0]     lfsr;
    logic [7:0]      fade;
    logic [7:0]      sh;
    logic [3:0]      bitc;
    logic [1:0]      byte_i;
    logic            rw;
    logic [15:0]     addr;
    logic            fv;
    logic            lv;
    logic            pclk;
    logic [15:0]     pix;
    logic            vid_oe_n;
    logic            trig;
    logic            trig_oe_n;
    logic            srst_n;
    logic            sda_o;
    logic            sda_oe_n;
    logic [3:0]      gpio_oe_n;
  } rsc_state_t;

  function automatic rsc_state_t rst_state();
    rsc_state_t r;
    r             = '0;
    r.main        = M_DEFAULT;
    r.mode_pend   = RST_CAMERA_OPERATING_MODE;
    r.choice_pend = RST_TEST_PATTERN_CHOICE;
    r.mode_act    = RST_CAMERA_OPERATING_MODE;
    r.choice_act  = RST_TEST_PATTERN_CHOICE;
    r.lfsr        = RST_LFSR_SEED;
    r.vid_oe_n    = 1'b1;
    r.trig_oe_n   = 1'b1;
    r.sda_oe_n    = 1'b1;
    r.gpio_oe_n   = 4'hf;
    return r;
  endfunction : rst_state

  // Luma of the eight colour bars, white first
  function automatic logic [7:0] bar_luma(input logic [2:0] idx);
    case (idx)
      3'h0:    bar_luma = 8'heb;
      3'h1:    bar_luma = 8'ha2;
      3'h2:    bar_luma = 8'h83;
      3'h3:    bar_luma = 8'h70;
      3'h4:    bar_luma = 8'h54;
      3'h5:    bar_luma = 8'h41;
      3'h6:    bar_luma = 8'h23;
      default: bar_luma = 8'h10;
    endcase
  endfunction : bar_luma

  function automatic logic is_bar(input logic [7:0] c);
    is_bar = (c == PAT_BAR_N7) || (c == PAT_BAR_N8) || (c == PAT_BAR_P7) || (c == PAT_BAR_P8);
  endfunction : is_bar

  function automatic logic [7:0] reg_read(input rsc_state_t s, input logic [15:0] a);
    case (a)
      OFS_CAMERA_OPERATING_MODE: reg_read = s.mode_pend;
      OFS_TEST_PATTERN_CHOICE:   reg_read = s.choice_pend;
      OFS_CONTROL_STATUS:        reg_read = {s.strap, s.run, s.sy != SY_IDLE, s.main == M_STANDBY,
                                             s.mode_act == MODE_TEST};
      default:                   reg_read = 8'h00;
    endcase
  endfunction : reg_read

  rsc_state_t st;
  rsc_state_t next_st;

  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] rise;
  logic [IN_W-1:0] fall;
  logic            pix_en;
  logic            frame_end;
  logic            restart;
  logic            halt;
  logic [7:0]      wbyte;

  // Two frames of pixels, counted in reference clocks
  localparam int STBY_LIMIT = 4 * H_TOTAL * V_TOTAL;

  assign pins = {gpio_in, ser_data_in, ser_clk_in, standby_in, frame_align_in};
  assign rise = st.filt & ~st.prev;
  assign fall = ~st.filt & st.prev;
  assign pix_en = st.pclk;
  assign frame_end = pix_en && st.run && (st.hcnt == HW'(H_TOTAL - 1)) && (st.vcnt == VW'(V_TOTAL - 1));
  assign wbyte = {st.sh[6:0], st.filt[IN_SDA]};

  always_comb begin
    next_st = st;
    restart = 1'b0;
    halt    = 1'b0;
    next_st.s1   = pins;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.filt = (st.s2 & ~(st.s2 ^ st.s3)) | (st.filt & (st.s2 ^ st.s3));
    next_st.prev = st.filt;
    next_st.pclk = ~st.pclk;
    next_st.sb_cnt = (st.main == M_STBY_WAIT) ? st.sb_cnt + 16'h0001 : '0;

    // Main sequencer
    case (st.main)
      M_DEFAULT: begin
        next_st.wait_cnt = st.wait_cnt + 12'h001;
        if (st.wait_cnt == {8'h00, STRAP_CYC}) begin
          next_st.strap    = st.filt[IN_GP +: 4];
          next_st.main     = M_RUN;
          next_st.vid_oe_n = 1'b0;
          next_st.srst_n   = 1'b1;
          next_st.run      = interlaced_mode;
        end
      end
      M_RUN: begin
        if (st.filt[IN_SB]) begin
          next_st.main = st.run ? M_STBY_WAIT : M_STANDBY;
        end
      end
      M_STBY_WAIT: begin
        if (frame_end) begin
          next_st.main = M_STANDBY;
          halt         = 1'b1;
        end
      end
      M_STANDBY: begin
        halt = 1'b1;
        if (!st.filt[IN_SB]) begin
          next_st.main = M_RUN;
          next_st.run  = interlaced_mode;
          restart      = 1'b1;
        end
      end
      M_SOFT: begin
        halt             = 1'b1;
        next_st.wait_cnt = st.wait_cnt + 12'h001;
        if (st.wait_cnt == SOFT_RST_CYC) begin
          next_st.main     = M_DEFAULT;
          next_st.wait_cnt = '0;
        end
      end
      default: next_st.main = M_DEFAULT;
    endcase

    next_st.trig_oe_n = interlaced_mode || (st.main == M_DEFAULT) || (st.main == M_SOFT);
    next_st.trig      = !interlaced_mode && st.filt[IN_FA];

    if (st.main == M_RUN) begin
      if (interlaced_mode) begin
        case (st.sy)
          SY_IDLE: begin
            if (rise[IN_FA]) begin
              next_st.sy = SY_STOP;
              halt       = 1'b1;
            end
          end
          SY_STOP: begin
            halt = 1'b1;
            if (fall[IN_FA]) begin
              next_st.sy  = SY_BLACK;
              next_st.fld = '0;
              next_st.run = 1'b1;
              restart     = 1'b1;
            end
          end
          SY_BLACK: begin
            if (frame_end) begin
              next_st.fld = st.fld + 4'h1;
              if (st.fld == RESYNC_FIELDS - 4'h1) begin
                next_st.sy = SY_IDLE;
              end
            end
          end
          default: next_st.sy = SY_IDLE;
        endcase
      end else begin
        next_st.sy = SY_IDLE;
        if (rise[IN_FA]) begin
          next_st.cont = trigger_continuous;
          next_st.run  = 1'b1;
          restart      = 1'b1;
        end else if (frame_end && !st.cont) begin
          next_st.run = 1'b0;
        end
      end
    end

    // Frame timing engine
    if (halt || restart) begin
      next_st.hcnt = '0;
      next_st.vcnt = '0;
      next_st.fv   = 1'b0;
      next_st.lv   = 1'b0;
      if (halt && !restart) begin
        next_st.run = 1'b0;
      end
    end else if (pix_en && st.run) begin
      next_st.hcnt = (st.hcnt == HW'(H_TOTAL - 1)) ? '0 : st.hcnt + 1'b1;
      if (st.hcnt == HW'(H_TOTAL - 1)) begin
        next_st.vcnt = (st.vcnt == VW'(V_TOTAL - 1)) ? '0 : st.vcnt + 1'b1;
        if (st.vcnt == VW'(V_TOTAL - 1)) begin
          next_st.fade = st.fade + 8'h01;
        end
      end
      next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
      next_st.fv   = st.vcnt < VW'(V_ACTIVE);
      next_st.lv   = (st.vcnt < VW'(V_ACTIVE)) && (st.hcnt < HW'(H_ACTIVE));
      if (st.sy == SY_BLACK || !(st.vcnt < VW'(V_ACTIVE)) || !(st.hcnt < HW'(H_ACTIVE))) begin
        next_st.pix = 16'h1080;
      end else if (st.mode_act != MODE_TEST) begin
        next_st.pix = sensor_data_in;
      end else begin
        case (st.choice_act)
          PAT_PRBS: next_st.pix = st.lfsr;
          PAT_FADE: next_st.pix = {st.fade, 8'h80};
          PAT_RAMP: next_st.pix = 16'(st.hcnt);
          default: begin
            if (is_bar(st.choice_act)) begin
              next_st.pix = {bar_luma(st.hcnt[HW-1 -: 3]), 8'h80};
            end else begin
              next_st.pix = 16'h8080;
            end
          end
        endcase
      end
    end

    if (apply_settings) begin
      if (st.mode_pend == MODE_TEST || st.mode_pend == MODE_NORMAL) begin
        next_st.mode_act = st.mode_pend;
      end
      if (!is_bar(st.choice_pend) || interlaced_mode) begin
        next_st.choice_act = st.choice_pend;
      end
    end

    // Two-wire serial slave, start and stop override any state
    if (st.filt[IN_SCL] && fall[IN_SDA]) begin
      next_st.ser      = SR_RX;
      next_st.bitc     = '0;
      next_st.byte_i   = '0;
      next_st.sda_oe_n = 1'b1;
    end else if (st.filt[IN_SCL] && rise[IN_SDA]) begin
      next_st.ser      = SR_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else begin
      case (st.ser)
        SR_IDLE: next_st.sda_oe_n = 1'b1;
        SR_RX: begin
          if (rise[IN_SCL]) begin
            next_st.sh   = wbyte;
            next_st.bitc = st.bitc + 4'h1;
          end else if (fall[IN_SCL] && st.bitc == 4'h8) begin
            next_st.bitc     = '0;
            next_st.ser      = SR_ACK;
            next_st.sda_oe_n = 1'b0;
            if (st.byte_i != 2'h3) begin
              next_st.byte_i = st.byte_i + 2'h1;
            end
            case (st.byte_i)
              2'h0: begin
                next_st.rw = st.sh[0];
                next_st.sh = reg_read(st, st.addr);
                if (st.sh[7:1] != DEV_ADDR) begin
                  next_st.ser      = SR_IDLE;
                  next_st.sda_oe_n = 1'b1;
                end
              end
              2'h1: next_st.addr[15:8] = st.sh;
              2'h2: next_st.addr[7:0] = st.sh;
              default: begin
                next_st.addr = st.addr + 16'h0001;
                if (st.addr == OFS_CAMERA_OPERATING_MODE) begin
                  next_st.mode_pend = st.sh;
                end
                if (st.addr == OFS_TEST_PATTERN_CHOICE) begin
                  next_st.choice_pend = st.sh;
                end
                if (st.addr == OFS_SOFT_RESET_CTRL && st.sh[0]) begin
                  next_st.main      = M_SOFT;
                  next_st.wait_cnt  = '0;
                  next_st.srst_n    = 1'b0;
                  next_st.mode_act  = RST_CAMERA_OPERATING_MODE;
                  next_st.choice_act = RST_TEST_PATTERN_CHOICE;
                  next_st.sy        = SY_IDLE;
                  next_st.cont      = 1'b0;
                end
              end
            endcase
          end
        end
        SR_ACK: begin
          if (fall[IN_SCL]) begin
            next_st.ser      = st.rw ? SR_TX : SR_RX;
            next_st.sda_oe_n = st.rw ? st.sh[7] : 1'b1;
          end
        end
        SR_TX: begin
          if (rise[IN_SCL]) begin
            next_st.bitc = st.bitc + 4'h1;
          end else if (fall[IN_SCL]) begin
            next_st.sh = {st.sh[6:0], 1'b0};
            if (st.bitc == 4'h8) begin
              next_st.ser      = SR_RACK;
              next_st.sda_oe_n = 1'b1;
            end else begin
              next_st.sda_oe_n = st.sh[6];
            end
          end
        end
        SR_RACK: begin
          if (rise[IN_SCL]) begin
            next_st.bitc = '0;
            if (st.filt[IN_SDA]) begin
              next_st.ser = SR_IDLE;
            end else begin
              next_st.addr = st.addr + 16'h0001;
              next_st.sh   = reg_read(st, st.addr + 16'h0001);
            end
          end else if (fall[IN_SCL]) begin
            next_st.ser      = SR_TX;
            next_st.sda_oe_n = st.sh[7];
          end
        end
        default: next_st.ser = SR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= rst_state();
    end else begin
      st <= next_st;
    end
  end

  assign frame_valid_output   = st.fv;
  assign line_valid_output    = st.lv;
  assign pixel_clock_output   = st.pclk;
  assign pixel_data_out       = st.pix;
  assign video_oe_n           = st.vid_oe_n;
  assign capture_trigger_out  = st.trig;
  assign capture_trigger_oe_n = st.trig_oe_n;
  assign sensor_reset_n_out   = st.srst_n;
  assign gpio_oe_n            = st.gpio_oe_n;
  assign ser_data_out         = st.sda_o;
  assign ser_data_oe_n        = st.sda_oe_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Reset itself must be watched, so the default disable is overridden
  reset_hiz_a: assert property (disable iff (1'b0) !rstn
    |=> video_oe_n && capture_trigger_oe_n && ser_data_oe_n && (&gpio_oe_n))
    else $error("outputs driven after reset");
  sensor_rst_a: assert property (st.main == M_DEFAULT |-> !sensor_reset_n_out)
    else $error("sensor reset released in default state");
  standby_entry_a: assert property (st.main == M_STBY_WAIT |-> int'(st.sb_cnt) < STBY_LIMIT)
    else $error("standby entry too slow");
  standby_exit_a: assert property (st.main == M_STANDBY && !st.filt[IN_SB] |=> st.main == M_RUN)
    else $error("standby not left");
  sync_stop_a: assert property (st.main == M_RUN && interlaced_mode && st.sy == SY_IDLE && rise[IN_FA]
    |=> ##1 !frame_valid_output)
    else $error("frame not stopped on sync rise");
  resync_ignore_a: assert property (st.sy == SY_BLACK && !frame_end |=> st.sy == SY_BLACK)
    else $error("resync disturbed");
  trig_fwd_a: assert property (!interlaced_mode && $rose(st.filt[IN_FA]) ##1 !interlaced_mode
    |-> capture_trigger_out)
    else $error("trigger not forwarded");
  single_stop_a: assert property (st.main == M_RUN && !interlaced_mode && !st.cont && frame_end
    && !rise[IN_FA] |=> !st.run)
    else $error("single shot kept running");
  apply_only_a: assert property (!apply_settings && st.main != M_SOFT |=> $stable(st.mode_act))
    else $error("mode changed without apply");
  bar_gate_a: assert property (apply_settings && !interlaced_mode && is_bar(st.choice_pend)
    |=> $stable(st.choice_act))
    else $error("bar pattern accepted in progressive");

endmodule : rsc_control
`default_nettype wire

//--- bench/rsc_host.sv
// Host model: two-wire serial master on a pulled-up data line
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
  // Clock
  input  wire logic clk,
  // Device pull-down
  input  wire logic dev_out,
  input  wire logic dev_oe_n,
  // Bus lines
  output var  logic scl,
  output wire logic sda
);
  logic drv;
  // Released line reads high through the pull-up
  assign sda = drv & (dev_oe_n | dev_out);
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  // Phases well above the input filter
  task automatic half();
    repeat (10) @(negedge clk);
  endtask : half
  task automatic start();
    drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    drv = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    drv = 1'b1;
    half();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], a);
      q[i] = a;
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask : xfer
  task automatic wr(input logic [6:0] dv, input logic [15:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    start();
    xfer({dv, 1'b0}, q, k0);
    xfer(a[15:8], q, k1);
    xfer(a[7:0], q, k2);
    xfer(d, q, k3);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask : wr
  task automatic rd(input logic [6:0] dv, input logic [15:0] a, output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic       k0, k1, k2, k3, k4;
    start();
    xfer({dv, 1'b0}, x, k0);
    xfer(a[15:8], x, k1);
    xfer(a[7:0], x, k2);
    start();
    xfer({dv, 1'b1}, x, k3);
    // Master answers the only byte with a release
    xfer(8'hff, q, k4);
    stop();
    ok = k0 & k1 & k2 & k3;
  endtask : rd
endmodule : rsc_host
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: register traffic, reset, standby, frame sync and test patterns
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import rsc_pkg::*;
;
  // Frame length in clk at the default timing parameters
  localparam int FRM = 16 * 64 * 2;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        standby_in = 1'b0;
  logic        frame_align_in = 1'b0;
  logic        interlaced_mode = 1'b1;
  logic        trigger_continuous = 1'b0;
  logic        apply_settings = 1'b0;
  logic [3:0]  gpio_in = 4'ha;
  logic [15:0] sensor_data_in = 16'h1234;
  wire logic   scl, sda, sdo, sdoe, fv, lv, pc, voe, ct, ctoe, srn;
  wire logic [15:0] pd;
  wire logic [3:0]  goe;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  int          t0;
  logic [7:0]  q;
  logic        ok;
  logic [7:0]  pats [3] = '{PAT_PRBS, PAT_FADE, PAT_RAMP};
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  rsc_control i_rsc_control (.clk(clk), .rstn(rstn), .standby_in(standby_in), .frame_align_in(frame_align_in),
    .gpio_in(gpio_in), .ser_clk_in(scl), .ser_data_in(sda), .ser_data_out(sdo), .ser_data_oe_n(sdoe),
    .interlaced_mode(interlaced_mode), .trigger_continuous(trigger_continuous), .apply_settings(apply_settings),
    .sensor_data_in(sensor_data_in), .frame_valid_output(fv), .line_valid_output(lv), .pixel_clock_output(pc),
    .pixel_data_out(pd), .video_oe_n(voe), .capture_trigger_out(ct), .capture_trigger_oe_n(ctoe),
    .sensor_reset_n_out(srn), .gpio_oe_n(goe));
  rsc_host i_rsc_host (.clk(clk), .dev_out(sdo), .dev_oe_n(sdoe), .scl(scl), .sda(sda));
  task automatic end_of_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_rsc_host.wr(7'h3a, a, d, ok);
    chk("wr_ack", ok, 1'b1);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    i_rsc_host.rd(7'h3a, a, q, ok);
    chk("rd_ack", ok, 1'b1);
  endtask : rd
  task automatic apply();
    apply_settings = 1'b1;
    @(negedge clk);
    apply_settings = 1'b0;
  endtask : apply
  // Bounded wait for frame valid (s=0) or line valid (s=1), then settle
  task automatic wt(input logic s, input logic v);
    int i;
    // Wait for a fresh edge, not a level already under way
    for (i = 0; i < 6000 && (s ? lv : fv) === v; i++)
      @(negedge clk);
    for (; i < 6000 && (s ? lv : fv) !== v; i++)
      @(negedge clk);
    if (i == 6000) begin
      chk("wait", s, ~s);
      end_of_test();
    end
    repeat (4) @(negedge clk);
  endtask : wt
  task automatic cnt_fv(input int len);
    logic p;
    // A frame already started by the trigger counts as well
    p = 1'b0;
    n = 0;
    repeat (len) begin
      @(negedge clk);
      if (fv === 1'b1 && p === 1'b0) n++;
      p = fv;
    end
  endtask : cnt_fv
  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    chk("oe_rst", {voe, ctoe, sdoe, goe}, 16'h007f);
    chk("srst_rst", srn, 1'b0);
    rstn = 1'b1;
    repeat (100) @(negedge clk);
    chk("gpio_rel", goe, 4'hf);
    rd(OFS_CONTROL_STATUS);
    chk("strap", q[7:4], 4'ha);
    wr(OFS_CAMERA_OPERATING_MODE, MODE_TEST);
    rd(OFS_CONTROL_STATUS);
    chk("no_apply", q[0], 1'b0);
    apply();
    rd(OFS_CONTROL_STATUS);
    chk("applied", q[0], 1'b1);
    foreach (pats[k]) begin
      wr(OFS_TEST_PATTERN_CHOICE, pats[k]);
      apply();
      rd(OFS_TEST_PATTERN_CHOICE);
      chk("pattern", q, pats[k]);
    end
    wt(1, 1'b1);
    chk("ramp", pd, 16'h0002);
    wr(OFS_TEST_PATTERN_CHOICE, PAT_BAR_N7);
    apply();
    wt(1, 1'b1);
    chk("bar", pd, 16'heb80);
    wr(OFS_TEST_PATTERN_CHOICE, 8'h00);
    apply();
    wt(1, 1'b1);
    chk("flat", pd, 16'h8080);
    rd(16'hc800);
    chk("unmapped", q, 8'h00);
    i_rsc_host.wr(7'h11, OFS_CAMERA_OPERATING_MODE, 8'h55, ok);
    chk("nack", ok, 1'b0);
    wr(OFS_CAMERA_OPERATING_MODE, MODE_NORMAL);
    apply();
    rd(OFS_CONTROL_STATUS);
    chk("left", q[0], 1'b0);
    wt(1, 1'b1);
    chk("sensor", pd, 16'h1234);
    ok = pc;
    @(negedge clk);
    chk("pclk", pc, !ok);
    wt(0, 1'b1);
    frame_align_in = 1'b1;
    repeat (8) @(negedge clk);
    chk("fv_stop", fv, 1'b0);
    frame_align_in = 1'b0;
    t0 = cyc;
    wt(1, 1'b1);
    chk("black", pd, 16'h1080);
    rd(OFS_CONTROL_STATUS);
    chk("busy", q[2], 1'b1);
    frame_align_in = 1'b1;
    repeat (10) @(negedge clk);
    frame_align_in = 1'b0;
    while (cyc < t0 + 2 * FRM + 300)
      @(negedge clk);
    rd(OFS_CONTROL_STATUS);
    chk("resync_end", q[2], 1'b0);
    interlaced_mode = 1'b0;
    repeat (FRM) @(negedge clk);
    frame_align_in = 1'b1;
    repeat (6) @(negedge clk);
    chk("trig_hi", {ctoe, ct}, 2'b01);
    frame_align_in = 1'b0;
    repeat (6) @(negedge clk);
    chk("trig_lo", ct, 1'b0);
    cnt_fv(3 * FRM);
    chk("single", n, 1);
    trigger_continuous = 1'b1;
    frame_align_in = 1'b1;
    repeat (6) @(negedge clk);
    frame_align_in = 1'b0;
    cnt_fv(3 * FRM);
    chk("cont", n >= 2, 1'b1);
    wr(OFS_TEST_PATTERN_CHOICE, PAT_BAR_P8);
    apply();
    standby_in = 1'b1;
    repeat (2 * FRM) @(negedge clk);
    chk("sb_fv", fv, 1'b0);
    rd(OFS_CONTROL_STATUS);
    chk("sb_in", q[1], 1'b1);
    repeat (10) @(negedge clk);
    standby_in = 1'b0;
    repeat (10) @(negedge clk);
    rd(OFS_CONTROL_STATUS);
    chk("sb_out", q[1], 1'b0);
    wr(OFS_SOFT_RESET_CTRL, 8'h01);
    chk("soft", srn, 1'b0);
    repeat (200) @(negedge clk);
    wr(OFS_CAMERA_OPERATING_MODE, MODE_TEST);
    rstn = 1'b0;
    repeat (50) @(negedge clk);
    chk("oe_rst2", {voe, ctoe, sdoe, goe}, 16'h007f);
    rstn = 1'b1;
    repeat (100) @(negedge clk);
    rd(OFS_CAMERA_OPERATING_MODE);
    chk("mode_rst", q, RST_CAMERA_OPERATING_MODE);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
